// >>> hw/comt_pkg.sv
/*
  Shared constants, register map and types of the current-output tag mapper.
  Assumes a 40 MHz APB clock and one field-device request port per module.
*/
package comt_pkg;
  localparam int NCH = 4;
  localparam int NBLK = 4;
  localparam int NEV = 7;

  // Register byte offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_IRQ_ST = 8'h04;
  localparam logic [7:0] A_IRQ_MSK = 8'h08;
  localparam logic [7:0] A_STATE = 8'h0C;
  localparam logic [7:0] A_CHCFG = 8'h10;
  localparam logic [7:0] A_OUTV = 8'h20;
  localparam logic [7:0] A_BLKCFG = 8'h30;
  localparam logic [7:0] A_BLKDAT = 8'h40;
  localparam logic [7:0] A_BLKST = 8'h50;
  localparam logic [7:0] A_SMOOTH = 8'h60;

  // Control register fields.
  localparam int CTRL_STOP = 0;
  localparam int CTRL_XCHG = 1;
  localparam int CTRL_FAST = 2;
  localparam int CTRL_WARN = 3;
  localparam int CTRL_DIAG = 4;
  localparam int CTRL_RETRY_LSB = 8;
  localparam int CTRL_EXT_LSB = 12;
  localparam logic [3:0] RETRY_RST = 4'h2;
  localparam logic [3:0] RETRY_MAX = 4'hA;
  localparam logic [2:0] EXT_RST = 3'h0;

  // Currents in microamps.
  localparam logic [15:0] I_MA0 = 16'h0000;
  localparam logic [15:0] I_MA4 = 16'h0FA0;

  // Event bits, shared by the block status byte and the interrupt status.
  localparam int EV_MORE = 0;
  localparam int EV_CFGCHG = 1;
  localparam int EV_CURSPEC = 2;
  localparam int EV_CURSAT = 3;
  localparam int EV_COMMERR = 4;
  localparam int EV_PVLIM = 5;
  localparam int EV_AVLIM = 6;

  // Poll timing.
  localparam int CLK_PERIOD_NS = 25;
  localparam int POLL_GAP_NS = 10000;
  localparam int RSP_TMO_NS = 50000;
  localparam logic [10:0] GAP_CYC = 11'(POLL_GAP_NS / CLK_PERIOD_NS);
  localparam logic [10:0] TMO_CYC = 11'(RSP_TMO_NS / CLK_PERIOD_NS);

  // Smoothing: log2 of samples per mean for each grade.
  localparam logic [2:0] SH_NONE = 3'h0;
  localparam logic [2:0] SH_LOW = 3'h2;
  localparam logic [2:0] SH_AVG = 3'h3;
  localparam logic [2:0] SH_STRONG = 3'h4;

  typedef enum logic [1:0] {RNG_OFF, RNG_0_20, RNG_4_20, RNG_HART} comt_range_t;
  typedef enum logic [1:0] {RCT_ZERO, RCT_SUBST, RCT_HOLD} comt_react_t;
  typedef enum logic [1:0] {SM_NONE, SM_LOW, SM_AVG, SM_STRONG} comt_smooth_t;
  typedef enum logic [2:0] {VAR_NONE, VAR_PV, VAR_AUX1, VAR_AUX2, VAR_AUX3}
    comt_var_t;
  typedef enum logic [1:0] {PS_IDLE = 2'b00, PS_REQ = 2'b01, PS_WAIT = 2'b11,
    PS_GAP = 2'b10} comt_poll_t;

  typedef struct packed {
    logic [15:0] subst;
    logic [9:0] pad;
    comt_smooth_t smooth;
    comt_react_t react;
    comt_range_t range;
  } comt_chcfg_t;

  typedef struct packed {
    logic [26:0] pad;
    comt_var_t var_sel;
    logic [1:0] chan;
  } comt_blkcfg_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    comt_var_t var_sel;
  } comt_fdreq_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [31:0] data;
    logic [7:0] status;
  } comt_fdrsp_t;

  localparam comt_chcfg_t CHCFG_RST = '{I_MA4, 10'h000, SM_NONE, RCT_SUBST,
    RNG_HART};
endpackage : comt_pkg

// >>> hw/comt_smooth.sv
/*
  Block-mean smoother for one channel of converted samples.
  Assumes samples arrive as one-cycle strobes on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module comt_smooth
  import comt_pkg::*;
(
  input wire logic pclk, // Bus clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire comt_pkg::comt_smooth_t grade, // Smoothing grade.
  input wire logic smp_valid, // Sample strobe.
  input wire logic [15:0] smp, // Converted sample.
  output var logic [15:0] avg_r // Latest mean.
);
  logic [19:0] acc_r;
  logic [3:0] cnt_r;
  logic [2:0] sh;
  logic [19:0] sum;
  comt_smooth_t grade_r;

  always_comb begin
    case (grade)
      SM_LOW: sh = SH_LOW; // [R03] [R04]
      SM_AVG: sh = SH_AVG; // [R04]
      SM_STRONG: sh = SH_STRONG; // [R04]
      default: sh = SH_NONE;
    endcase
    sum = acc_r + {4'h0, smp};
  end

  // A grade change restarts the window so no mean mixes two grades.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
      cnt_r <= '0;
      avg_r <= '0;
      grade_r <= SM_NONE;
    end else if (grade != grade_r) begin
      grade_r <= grade;
      acc_r <= '0;
      cnt_r <= '0;
    end else if (smp_valid) begin
      if (cnt_r == 4'((5'h01 << sh) - 5'h01)) begin
        avg_r <= 16'(sum >> sh); // [R03]
        acc_r <= '0;
        cnt_r <= '0;
      end else begin
        acc_r <= sum;
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule : comt_smooth
`default_nettype wire

// >>> hw/comt_top.sv
/*
  Control core of a four-channel current-output module: APB registers,
  stop reaction, substitute values, smoothing, field-device tag polling
  into the input image and diagnostic interrupts.
  Assumes the field-device link logic and the substitute store share pclk.
*/
// Design decisions made here: the register addresses and the APB register port.
// How it works
// R01: On stop: zero, substitute or hold per channel; substitute by default.
// R02: Stored substitutes drive outputs after power-up until exchange starts.
// R03: Smoothing outputs the mean of a grade-selected number of samples.
// R04: Stronger grades average more samples and settle more slowly.
// R05: Input image holds four 5-byte tag blocks, 20 bytes in total.
// R06: The configured count, one to four, selects how many blocks carry tags; the code also accepts 0, which is its reset value.
// R07: Each block has a channel selector, 0 to 3, default 0.
// R08: Each block selects none, primary or auxiliary one to three; default none.
// R09: The field device must provide every variable assigned to it.
// R10: Failed transactions retry 0 to 10 times, default 2, then report error.
// R11: Fast command mode polls back to back without gaps; off by default.
// R12: Warning enable gates more-status and config-changed interrupts.
// R13: Diagnostics enable gates current, communication and limit interrupts.
// R14: Blocks set to none are never polled and read as zero.
`timescale 1ns/1ps
`default_nettype none
module comt_top (
  input wire logic pclk, // Bus clock, 40 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output var logic [31:0] prdata, // APB read data.
  output var logic pready, // APB ready.
  output var logic pslverr, // APB error on unmapped address.
  input wire logic [comt_pkg::NCH-1:0] adc_valid, // Sample strobes.
  input wire logic [comt_pkg::NCH-1:0][15:0] adc_data, // Samples.
  output var logic [comt_pkg::NCH-1:0][15:0] ao_value, // Output currents.
  input wire logic nv_rd_valid, // Stored substitutes valid.
  input wire logic [comt_pkg::NCH-1:0][15:0] nv_rd_data, // Stored values.
  output var logic nv_wr, // Store one substitute, pulse.
  output var logic [1:0] nv_wr_chan, // Channel to store.
  output var logic [15:0] nv_wr_data, // Value to store.
  output var comt_pkg::comt_fdreq_t fd_req, // Field-device request.
  input wire comt_pkg::comt_fdrsp_t fd_rsp, // Field-device response.
  output var logic irq // Diagnostic interrupt, level.
);
  import comt_pkg::*;

  logic stop_r, xchg_r, fast_r, warn_en_r, diag_en_r;
  logic [3:0] retries_r;
  logic [2:0] ext_r;
  logic exch_seen_r, nv_loaded_r;
  comt_chcfg_t chcfg_r [NCH];
  logic [15:0] outv_r [NCH];
  logic [15:0] ao_r [NCH];
  logic [15:0] sm_val [NCH];
  comt_blkcfg_t blkcfg_r [NBLK];
  logic [31:0] blk_data_r [NBLK];
  logic [7:0] blk_st_r [NBLK];
  logic [NBLK-1:0] blk_act;
  logic [NEV-1:0] irq_st_r, irq_msk_r, ev_set;
  comt_poll_t st_r;
  logic [1:0] idx_r;
  logic [3:0] tries_r;
  logic [10:0] tmr_r;
  comt_fdreq_t fd_req_r;
  logic [31:0] prdata_r, rd_val;
  logic pready_r, pslverr_r, irq_r, nv_wr_r;
  logic [1:0] nv_wr_chan_r;
  logic [15:0] nv_wr_data_r;
  logic hit, acc_wr, wr_ctrl, wr_irqst, wr_irqmsk, wr_chcfg, wr_outv, wr_blk;
  logic [1:0] ix;
  logic [3:0] retry_wr;
  comt_chcfg_t wr_cfg;
  logic rsp_ok, fail, give_up;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign nv_wr = nv_wr_r;
  assign nv_wr_chan = nv_wr_chan_r;
  assign nv_wr_data = nv_wr_data_r;
  assign fd_req = fd_req_r;

  // Address decode; every access completes with no wait state.
  always_comb begin
    ix = paddr[3:2];
    hit = (paddr[1:0] == 2'h0);
    rd_val = '0;
    if (paddr == A_CTRL) begin
      rd_val[CTRL_STOP] = stop_r;
      rd_val[CTRL_XCHG] = xchg_r;
      rd_val[CTRL_FAST] = fast_r;
      rd_val[CTRL_WARN] = warn_en_r;
      rd_val[CTRL_DIAG] = diag_en_r;
      rd_val[CTRL_RETRY_LSB +: 4] = retries_r;
      rd_val[CTRL_EXT_LSB +: 3] = ext_r;
    end else if (paddr == A_IRQ_ST) begin
      rd_val[NEV-1:0] = irq_st_r;
    end else if (paddr == A_IRQ_MSK) begin
      rd_val[NEV-1:0] = irq_msk_r;
    end else if (paddr == A_STATE) begin
      rd_val = {24'h0, tries_r, idx_r, exch_seen_r, nv_loaded_r};
    end else if (paddr[7:4] == A_CHCFG[7:4]) begin
      rd_val = chcfg_r[ix];
    end else if (paddr[7:4] == A_OUTV[7:4]) begin
      rd_val = {16'h0, outv_r[ix]};
    end else if (paddr[7:4] == A_BLKCFG[7:4]) begin
      rd_val = blkcfg_r[ix];
    end else if (paddr[7:4] == A_BLKDAT[7:4]) begin
      rd_val = blk_data_r[ix]; // [R05]
    end else if (paddr[7:4] == A_BLKST[7:4]) begin
      rd_val = {24'h0, blk_st_r[ix]}; // [R05]
    end else if (paddr[7:4] == A_SMOOTH[7:4]) begin
      rd_val = {16'h0, sm_val[ix]};
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    acc_wr = psel && penable && pwrite && pready_r && hit;
    wr_ctrl = acc_wr && (paddr == A_CTRL);
    wr_irqst = acc_wr && (paddr == A_IRQ_ST);
    wr_irqmsk = acc_wr && (paddr == A_IRQ_MSK);
    wr_chcfg = acc_wr && (paddr[7:4] == A_CHCFG[7:4]);
    wr_outv = acc_wr && (paddr[7:4] == A_OUTV[7:4]);
    wr_blk = acc_wr && (paddr[7:4] == A_BLKCFG[7:4]);
    retry_wr = pwdata[CTRL_RETRY_LSB +: 4];
    if (retry_wr > RETRY_MAX) begin
      retry_wr = RETRY_MAX; // [R10]
    end
    // A range change with the substitute left alone takes the range default.
    wr_cfg = comt_chcfg_t'(pwdata);
    wr_cfg.pad = '0;
    if (wr_cfg.range != chcfg_r[ix].range &&
        wr_cfg.subst == chcfg_r[ix].subst) begin
      wr_cfg.subst = (wr_cfg.range == RNG_0_20) ? I_MA0 : I_MA4; // [R01]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !hit;
      prdata_r <= (psel && !penable && !pwrite) ? rd_val : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_r <= 1'b0;
      xchg_r <= 1'b0;
      fast_r <= 1'b0; // [R11]
      warn_en_r <= 1'b0; // [R12]
      diag_en_r <= 1'b0; // [R13]
      retries_r <= RETRY_RST; // [R10]
      ext_r <= EXT_RST;
      exch_seen_r <= 1'b0;
    end else if (wr_ctrl) begin
      stop_r <= pwdata[CTRL_STOP];
      xchg_r <= pwdata[CTRL_XCHG];
      fast_r <= pwdata[CTRL_FAST];
      warn_en_r <= pwdata[CTRL_WARN];
      diag_en_r <= pwdata[CTRL_DIAG];
      retries_r <= retry_wr;
      ext_r <= (pwdata[CTRL_EXT_LSB +: 3] > 3'h4) ? 3'h4 :
               pwdata[CTRL_EXT_LSB +: 3]; // [R06]
      if (pwdata[CTRL_XCHG]) begin
        exch_seen_r <= 1'b1; // [R02]
      end
    end
  end

  // Substitutes come back from the store once after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_loaded_r <= 1'b0;
      nv_wr_r <= 1'b0;
      nv_wr_chan_r <= '0;
      nv_wr_data_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        chcfg_r[c] <= CHCFG_RST;
        outv_r[c] <= '0;
      end
    end else begin
      nv_wr_r <= 1'b0;
      if (nv_rd_valid && !nv_loaded_r) begin
        nv_loaded_r <= 1'b1;
        for (int c = 0; c < NCH; c++) begin
          chcfg_r[c].subst <= nv_rd_data[c]; // [R02]
        end
      end
      if (wr_chcfg) begin
        chcfg_r[ix] <= wr_cfg;
        nv_wr_r <= (wr_cfg.subst != chcfg_r[ix].subst); // [R02]
        nv_wr_chan_r <= ix;
        nv_wr_data_r <= wr_cfg.subst;
      end
      if (wr_outv) begin
        outv_r[ix] <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < NBLK; b++) begin
        blkcfg_r[b] <= '{27'h0, VAR_NONE, 2'h0}; // [R07] [R08]
      end
    end else if (wr_blk) begin
      blkcfg_r[ix] <= '{27'h0, comt_var_t'(pwdata[4:2]), pwdata[1:0]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      comt_smooth u_smooth (
        .pclk(pclk),
        .presetn(presetn),
        .grade(chcfg_r[g].smooth),
        .smp_valid(adc_valid[g]),
        .smp(adc_data[g]),
        .avg_r(sm_val[g])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ao_r[g] <= I_MA0;
        end else if (chcfg_r[g].range == RNG_OFF) begin
          ao_r[g] <= I_MA0;
        end else if (!exch_seen_r) begin
          ao_r[g] <= chcfg_r[g].subst; // [R02]
        end else if (stop_r) begin
          case (chcfg_r[g].react)
            RCT_ZERO: ao_r[g] <= I_MA0; // [R01]
            RCT_HOLD: ao_r[g] <= ao_r[g]; // [R01]
            default: ao_r[g] <= chcfg_r[g].subst; // [R01]
          endcase
        end else begin
          ao_r[g] <= outv_r[g];
        end
      end
    end
  endgenerate
  assign ao_value = {ao_r[3], ao_r[2], ao_r[1], ao_r[0]};

  always_comb begin
    for (int b = 0; b < NBLK; b++) begin
      blk_act[b] = (3'(b) < ext_r) &&
                   (blkcfg_r[b].var_sel != VAR_NONE); // [R06] [R14]
    end
    rsp_ok = (st_r == PS_WAIT) && fd_rsp.valid && fd_rsp.ok;
    // A refused or missing variable counts as a failed transaction.
    fail = (st_r == PS_WAIT) && ((fd_rsp.valid && !fd_rsp.ok) ||
           (!fd_rsp.valid && tmr_r == TMO_CYC)); // [R09]
    give_up = fail && (tries_r >= retries_r); // [R10]
  end

  // Poll sequencer walks the blocks; fast mode drops the inter-poll gap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= PS_IDLE;
      idx_r <= '0;
      tries_r <= '0;
      tmr_r <= '0;
      fd_req_r <= '0;
    end else begin
      fd_req_r.valid <= 1'b0;
      case (st_r)
        PS_IDLE: begin
          if (blk_act[idx_r]) begin
            st_r <= PS_REQ;
          end else begin
            idx_r <= idx_r + 2'h1; // [R14]
          end
        end
        PS_REQ: begin
          fd_req_r.valid <= 1'b1;
          fd_req_r.chan <= blkcfg_r[idx_r].chan; // [R07]
          fd_req_r.var_sel <= blkcfg_r[idx_r].var_sel; // [R08]
          tmr_r <= '0;
          st_r <= PS_WAIT;
        end
        PS_WAIT: begin
          tmr_r <= tmr_r + 11'h001;
          if (rsp_ok || give_up) begin
            tries_r <= '0;
            idx_r <= idx_r + 2'h1;
            tmr_r <= '0;
            st_r <= fast_r ? PS_IDLE : PS_GAP; // [R11]
          end else if (fail) begin
            tries_r <= tries_r + 4'h1; // [R10]
            st_r <= PS_REQ;
          end
        end
        PS_GAP: begin
          if (tmr_r >= GAP_CYC - 11'h001) begin
            tmr_r <= '0;
            st_r <= PS_IDLE;
          end else begin
            tmr_r <= tmr_r + 11'h001;
          end
        end
        default: st_r <= PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < NBLK; b++) begin
        blk_data_r[b] <= '0;
        blk_st_r[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NBLK; b++) begin
        if (!blk_act[b]) begin
          blk_data_r[b] <= '0; // [R14]
          blk_st_r[b] <= '0; // [R14]
        end else if (idx_r == 2'(b) && rsp_ok) begin
          blk_data_r[b] <= fd_rsp.data; // [R05] [R06]
          blk_st_r[b] <= fd_rsp.status;
        end else if (idx_r == 2'(b) && give_up) begin
          blk_st_r[b][EV_COMMERR] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    ev_set = '0;
    if (rsp_ok) begin
      ev_set[EV_MORE] = warn_en_r && fd_rsp.status[EV_MORE]; // [R12]
      ev_set[EV_CFGCHG] = warn_en_r && fd_rsp.status[EV_CFGCHG]; // [R12]
      ev_set[EV_CURSPEC] = diag_en_r && fd_rsp.status[EV_CURSPEC]; // [R13]
      ev_set[EV_CURSAT] = diag_en_r && fd_rsp.status[EV_CURSAT]; // [R13]
      ev_set[EV_PVLIM] = diag_en_r && fd_rsp.status[EV_PVLIM]; // [R13]
      ev_set[EV_AVLIM] = diag_en_r && fd_rsp.status[EV_AVLIM]; // [R13]
    end
    ev_set[EV_COMMERR] = diag_en_r && give_up; // [R10] [R13]
  end

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= '0;
      irq_msk_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~(wr_irqst ? pwdata[NEV-1:0] : '0)) | ev_set;
      if (wr_irqmsk) begin
        irq_msk_r <= pwdata[NEV-1:0];
      end
      irq_r <= |(irq_st_r & irq_msk_r);
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_stop_zero_out: assert property ( // [R01]
    exch_seen_r && stop_r && chcfg_r[0].react == RCT_ZERO &&
    chcfg_r[0].range != RNG_OFF |=> ao_value[0] == I_MA0)
    else $error("stop with zero reaction did not zero the output");
  chk_stop_hold_out: assert property ( // [R01]
    exch_seen_r && stop_r && chcfg_r[0].react == RCT_HOLD &&
    chcfg_r[0].range != RNG_OFF ##1 stop_r && chcfg_r[0].react == RCT_HOLD
    |-> $stable(ao_value[0]))
    else $error("hold reaction changed the output");
  chk_startup_subst: assert property ( // [R02]
    !exch_seen_r && chcfg_r[2].range != RNG_OFF
    |=> ao_value[2] == $past(chcfg_r[2].subst))
    else $error("output not substitute before exchange");
  chk_retry_bound: assert property ( // [R10]
    retries_r <= RETRY_MAX && tries_r <= retries_r)
    else $error("retry count out of range");
  chk_commerr_after_retry: assert property ( // [R10]
    $rose(irq_st_r[EV_COMMERR]) |-> $past(tries_r == retries_r && fail))
    else $error("communication error before retries ran out");
  chk_poll_active_only: assert property ( // [R14]
    st_r == PS_REQ |=> fd_req.valid && fd_req.var_sel != VAR_NONE)
    else $error("request for an unassigned block");
  chk_fast_no_gap: assert property ( // [R11]
    fast_r && (rsp_ok || give_up) |=> st_r == PS_IDLE)
    else $error("fast mode inserted a poll gap");
  chk_warn_gate: assert property ( // [R12]
    !warn_en_r |-> !ev_set[EV_MORE] && !ev_set[EV_CFGCHG])
    else $error("warning interrupt raised while disabled");
  chk_diag_gate: assert property ( // [R13]
    !diag_en_r |-> (ev_set & 7'h7C) == 7'h00)
    else $error("diagnostic interrupt raised while disabled");
  chk_idle_block_zero: assert property ( // [R14]
    !blk_act[3] |=> blk_data_r[3] == 32'h0000_0000 && blk_st_r[3] == 8'h00)
    else $error("inactive block not neutral");
  chk_irq_follows: assert property (
    (irq_st_r & irq_msk_r) != 7'h00 |=> irq)
    else $error("unmasked status did not raise interrupt");

  cov_retry: cover property (fail && !give_up ##1 st_r == PS_REQ);
  cov_commerr: cover property (give_up);
  cov_fast_poll: cover property (fast_r && rsp_ok ##2 st_r == PS_REQ);
  cov_irq: cover property ($rose(irq));
endmodule : comt_top
`default_nettype wire

// >>> tb/comt_fdev.sv
/*
  Field-device responder model for the tag poller.
  Assumes requests arrive as one-cycle pulses on pclk, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module comt_fdev
  import comt_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire comt_pkg::comt_fdreq_t fd_req, // Request.
  input wire logic [3:0] lat, // Answer delay in cycles.
  input wire logic fail_ld, // Load the count of bad answers.
  input wire logic [3:0] fail_n, // Bad answers to give next.
  input wire logic [7:0] stat, // Status byte sent back.
  output var comt_pkg::comt_fdrsp_t fd_rsp // Answer.
);
  logic busy_r;
  logic [3:0] cnt_r;
  logic [3:0] left_r;
  comt_fdreq_t q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      left_r <= 4'h0;
      q_r <= '0;
      fd_rsp <= '0;
    end else begin
      fd_rsp.valid <= 1'b0;
      // Data lines change while idle so stale values are never trusted.
      fd_rsp.data <= ~fd_rsp.data;
      if (fail_ld) begin
        left_r <= fail_n;
      end
      if (fd_req.valid) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
        q_r <= fd_req;
      end else if (busy_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        fd_rsp.valid <= 1'b1;
        fd_rsp.ok <= (left_r == 4'h0);
        fd_rsp.data <= {16'h3F80, 11'h000, q_r.chan, q_r.var_sel};
        fd_rsp.status <= stat;
        if (left_r != 4'h0 && !fail_ld) begin
          left_r <= left_r - 4'h1;
        end
      end
    end
  end
endmodule : comt_fdev
`default_nettype wire

// >>> tb/testbench.sv
/*
  Self-checking bench for the current-output tag mapper.
  Assumes the APB slave answers with pready and a responder model.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import comt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, nv_wr, irq, nv_rd_valid = 1'b1;
  logic [NCH-1:0] adc_valid = '0;
  logic [NCH-1:0][15:0] adc_data = '0, ao_value, nv = '0;
  logic [1:0] nv_wr_chan;
  logic [15:0] nv_wr_data, v;
  comt_fdreq_t fd_req;
  comt_fdrsp_t fd_rsp;
  logic [3:0] lat = 4'h0, fail_n = 4'h0;
  logic fail_ld = 1'b0;
  logic [7:0] stat = 8'h00;
  int mismatches = 0, n_tests = 0, sum;
  logic [31:0] cfg [4] = '{32'h0FA00003, 32'h0FA00007, 32'h0FA0000B,
    32'h0FA00005};

  logic [7:0] nv_cnt = 8'h00;

  always #12.5 pclk = ~pclk;

  // Counts store pulses so a missing or repeated one shows up.
  always @(posedge pclk) nv_cnt <= nv_cnt + {7'h0, nv_wr === 1'b1};

  comt_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_valid(adc_valid), .adc_data(adc_data), .ao_value(ao_value),
    .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv), .nv_wr(nv_wr),
    .nv_wr_chan(nv_wr_chan), .nv_wr_data(nv_wr_data), .fd_req(fd_req),
    .fd_rsp(fd_rsp), .irq(irq));

  comt_fdev fdev (.pclk(pclk), .presetn(presetn), .fd_req(fd_req),
    .lat(lat), .fail_ld(fail_ld), .fail_n(fail_n), .stat(stat),
    .fd_rsp(fd_rsp));

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Output expected under stop; a 0-20 mA range falls back to 0 mA unless the reaction is hold.
  function automatic logic [15:0] stop_exp(input logic [31:0] c,
    input logic [15:0] last);
    if (c[3:2] == 2'h2) begin
      return last;
    end else if (c[3:2] == 2'h0 || c[1:0] == 2'h1) begin
      return I_MA0;
    end
    return c[31:16];
  endfunction : stop_exp

  // Called just after a rising edge; returns just after one too.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wait_req(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (fd_req.valid !== 1'b1 && k < 300);
      lat <= 4'($urandom % 8);
      v = {10'h0, (k < 300), fd_req.chan, fd_req.var_sel};
      chk({16'h0, v}, 32'h31, "poll");
    end
  endtask : wait_req

  task test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    #(25 * 40000);
    mismatches++;
    test_done();
  end

  initial begin
    void'($urandom(55));
    for (int c = 0; c < NCH; c++) nv[c] <= 16'($urandom % 16'h5000);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    nv_rd_valid <= 1'b0;
    for (int c = 0; c < NCH; c++) begin
      chk({16'h0, ao_value[c]}, {16'h0, nv[c]}, "stored subst");
    end
    apb(1'b0, A_CTRL, 32'h0);
    chk(q, 32'h00000200, "ctrl reset");
    apb(1'b0, A_BLKCFG + 8'h8, 32'h0);
    chk(q, 32'h0, "blkcfg reset");
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom % 16'h5000);
      apb(1'b1, A_CHCFG, cfg[i]);
      apb(1'b1, A_OUTV, {16'h0, v});
      apb(1'b1, A_CTRL, 32'h00000202);
      repeat (2) @(posedge pclk);
      chk({16'h0, ao_value[0]}, {16'h0, v}, "run");
      apb(1'b1, A_CTRL, 32'h00000203);
      apb(1'b1, A_OUTV, {16'h0, ~v});
      repeat (2) @(posedge pclk);
      q = {16'h0, stop_exp(cfg[i], v)};
      chk({16'h0, ao_value[0]}, q, "stop");
    end
    // Channel 0 stored twice: new substitute, then the 0-20 mA default.
    q = {6'h0, nv_cnt, nv_wr_chan, nv_wr_data};
    chk(q, {6'h0, 8'h02, 2'h0, I_MA0}, "store");
    for (int g = 0; g < 4; g++) begin
      sum = 0;
      apb(1'b1, A_CHCFG + 8'h4, 32'h0FA00007 | (g << 4));
      for (int i = 0; i < (1 << (g + (g > 0))); i++) begin
        v = 16'($urandom);
        sum += v;
        adc_valid <= 4'h2;
        adc_data[1] <= v;
        @(posedge pclk);
        adc_valid <= 4'h0;
        @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
      apb(1'b0, A_SMOOTH + 8'h4, 32'h0);
      chk(q, sum >> (g + (g > 0)), "mean");
    end
    stat <= 8'h01;
    fail_ld <= 1'b1;
    fail_n <= 4'h2;
    apb(1'b1, A_IRQ_MSK, 32'h7F);
    fail_ld <= 1'b0;
    apb(1'b1, A_BLKCFG, 32'h6);
    apb(1'b1, A_CTRL, 32'h0000221E);
    wait_req(5);
    repeat (20) @(posedge pclk);
    apb(1'b0, A_BLKDAT, 32'h0);
    chk(q, 32'h3F800011, "tag data");
    apb(1'b0, A_BLKST, 32'h0);
    chk(q, 32'h1, "tag status");
    apb(1'b0, A_BLKDAT + 8'h4, 32'h0);
    chk(q, 32'h0, "unused block");
    apb(1'b0, A_IRQ_ST, 32'h0);
    chk(q, 32'h1, "warn status");
    chk({31'h0, irq}, 32'h1, "warn irq");
    stat <= 8'h00;
    wait_req(2);
    repeat (20) @(posedge pclk);
    apb(1'b1, A_IRQ_ST, 32'h7F);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq clear");
    fail_ld <= 1'b1;
    // Three bad answers in a row exhaust the two retries of one poll.
    fail_n <= 4'h3;
    apb(1'b1, A_CTRL, 32'h0000221E);
    fail_ld <= 1'b0;
    wait_req(3);
    repeat (20) @(posedge pclk);
    apb(1'b0, A_IRQ_ST, 32'h0);
    chk(q, 32'h10, "commerr status");
    chk({31'h0, irq}, 32'h1, "commerr irq");
    test_done();
  end
endmodule : testbench
`default_nettype wire
